// *** dv/nand_dev_model.sv ***
// Behavioural flash device for page read, column change and status read
`timescale 1ns/1ns
`default_nettype none
module nand_dev_model #(
   parameter int FAST_BUSY_NS = 400,
   parameter int SLOW_BUSY_NS = 3000
) (
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic powerup_protect_pin,
   input wire logic [7:0] io_bus,
   input wire logic slow,
   output logic [7:0] io_drv,
   output logic busy_pull_low,
   output logic standby,
   output int proto_errs
);
   // ************************************************************
   // Array state and bus decode
   // ************************************************************
   logic [7:0] acyc [5];
   logic [7:0] last;
   logic [11:0] col;
   logic [17:0] row;
   logic drive_en, status_mode, array_protect;
   logic plane_select_bit;
   logic prog_allowed;
   int n_addr;
   assign plane_select_bit = row[6];
   assign prog_allowed = wp_n & ~array_protect;
   assign io_drv = drive_en ? last : ~last;
   initial begin
      proto_errs = 0;
      drive_en = 1'b0;
      last = 8'h00;
      status_mode = 1'b0;
      busy_pull_low = 1'b0;
      standby = 1'b1;
      n_addr = 0;
      col = 12'h000;
      row = 18'h00000;
      #1 array_protect = powerup_protect_pin;
   end
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         case (io_bus)
            8'h00: begin
               status_mode = 1'b0;
               n_addr = 0;
            end
            8'h05: n_addr = 0;
            8'h30: begin
               if (n_addr != 5 || acyc[1][7:4] != 4'h0 || acyc[4][7:2] != 6'h00) proto_errs++;
               col = {acyc[1][3:0], acyc[0]};
               row = {acyc[4][1:0], acyc[3], acyc[2]};
               busy_pull_low = 1'b1;
               busy_pull_low <= #(slow ? SLOW_BUSY_NS : FAST_BUSY_NS) 1'b0;
            end
            8'hE0: begin
               if (n_addr != 2 || acyc[1][7:4] != 4'h0) proto_errs++;
               col = {acyc[1][3:0], acyc[0]};
            end
            8'h70: status_mode = 1'b1;
            default: ;
         endcase
      end else if (!ce_n && ale) begin
         if (n_addr < 5) acyc[n_addr] = io_bus;
         n_addr++;
      end else if (!ce_n) begin
         proto_errs++;
      end
   end
   always @(negedge read_strobe_n) begin
      if (!ce_n) begin
         if (busy_pull_low) proto_errs++;
         if (status_mode) last = {1'b0, !busy_pull_low, !busy_pull_low, 5'h00};
         else last = col[7:0] ^ {col[11:8], col[11:8]} ^ {row[7], plane_select_bit, row[5:0]}
                     ^ row[15:8] ^ {6'h00, row[17:16]};
         if (!status_mode) col = (col == 12'h83F) ? 12'h000 : col + 12'h001;
         #20 drive_en = 1'b1;
      end
   end
   always @(posedge read_strobe_n) #10 drive_en = 1'b0;
   always @(posedge ce_n) standby = !busy_pull_low;
   always @(negedge ce_n) standby = 1'b0;
endmodule : nand_dev_model
`default_nettype wire

// *** dv/tb_nand_host_ctrl.sv ***
// Self-checking bench for the flash page read controller
`timescale 1ns/1ns
`default_nettype none
module tb_nand_host_ctrl;
   // ************************************************************
   // Harness
   // ************************************************************
   logic mclk, nrst, req_valid, slow, req_ready, rd_valid, done, status_ready_bit, status_idle_bit;
   logic dev_busy, dev_standby, rb_wire;
   logic after_status;
   logic [7:0] rd_data, io_wire, dev_io;
   logic [15:0] lfsr_state, r;
   logic [17:0] cur_row;
   logic [11:0] cl, ln;
   nand_host_pkg::req_t req_in;
   nand_host_pkg::pins_t pins;
   int dev_errs, n_errors, compares;
   assign io_wire = pins.io_oe ? pins.io_out : dev_io;
   assign rb_wire = dev_busy ? 1'b0 : 1'b1;
   nand_host_ctrl u_dut (.mclk(mclk), .nrst(nrst), .req_valid(req_valid), .req_in(req_in),
      .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
      .status_ready_bit(status_ready_bit), .status_idle_bit(status_idle_bit), .io_in(io_wire),
      .ready_busy_n(rb_wire), .pins(pins));
   nand_dev_model u_dev (.ce_n(pins.ce_n), .cle(pins.cle), .ale(pins.ale), .we_n(pins.we_n),
      .read_strobe_n(pins.read_strobe_n), .wp_n(pins.wp_n), .powerup_protect_pin(pins.powerup_protect_pin),
      .io_bus(io_wire), .slow(slow), .io_drv(dev_io), .busy_pull_low(dev_busy), .standby(dev_standby),
      .proto_errs(dev_errs));
   always #25 mclk = ~mclk;
   function automatic logic [15:0] rnd();
      lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
      return lfsr_state;
   endfunction : rnd
   function automatic logic [7:0] exp_byte(input logic [17:0] rw, input logic [11:0] c);
      return c[7:0] ^ {c[11:8], c[11:8]} ^ rw[7:0] ^ rw[15:8] ^ {6'h00, rw[17:16]};
   endfunction : exp_byte
   function automatic int nbytes(input logic [11:0] l);
      return (l == 12'h000) ? 1 : ((l > 12'h840) ? 2112 : int'(l));
   endfunction : nbytes
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : check
   task automatic final_report;
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   // ************************************************************
   // One request, bytes compared as they arrive
   // ************************************************************
   task automatic run(input nand_host_pkg::op_t op, input logic [11:0] col, input logic [17:0] rw,
                      input logic [11:0] len);
      int n, got, k;
      logic [11:0] c;
      n = (op == nand_host_pkg::OP_STATUS) ? 1 : nbytes(len);
      got = 0;
      k = 0;
      c = col;
      req_in = '{op: op, col: col, row: rw, len: len};
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && k < 100) begin
         @(negedge mclk);
         k++;
      end
      @(negedge mclk);
      req_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20000) begin
         @(negedge mclk);
         k++;
         if (rd_valid === 1'b1 && op == nand_host_pkg::OP_STATUS) begin
            check(rd_data[6:5] === 2'b11, "status byte");
         end else if (rd_valid === 1'b1) begin
            check(rd_data === exp_byte(rw, c), "read byte");
            c++;
         end
         if (rd_valid === 1'b1) got++;
      end
      check(got == n && done === 1'b1, "byte count or done");
      if (op == nand_host_pkg::OP_STATUS) check(status_ready_bit === 1'b1 && status_idle_bit === 1'b1,
         "status bits");
      @(negedge mclk);
      check(pins.ce_n === 1'b1 && pins.io_oe === 1'b0 && dev_standby === 1'b1, "idle release");
      check(pins.wp_n === 1'b0 && pins.powerup_protect_pin === 1'b0, "protect pins");
   endtask : run
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      req_valid = 1'b0;
      req_in = '0;
      slow = 1'b0;
      lfsr_state = 16'h0037;
      n_errors = 0;
      compares = 0;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      check(pins.ce_n === 1'b1 && pins.io_oe === 1'b0, "reset pins");
      run(nand_host_pkg::OP_PAGE_READ, 12'h000, 18'h00040, 12'h000);
      cur_row = 18'h3FFFF;
      run(nand_host_pkg::OP_PAGE_READ, 12'h83E, cur_row, 12'h002);
      run(nand_host_pkg::OP_RANDOM_OUT, 12'h7FF, cur_row, 12'h002);
      run(nand_host_pkg::OP_STATUS, 12'h000, cur_row, 12'h000);
      slow = 1'b1;
      cur_row = 18'h2A5C3;
      run(nand_host_pkg::OP_PAGE_READ, 12'h000, cur_row, 12'hFFF);
      // Column change after a status read would return status, so it follows a data op only
      after_status = 1'b0;
      for (int i = 0; i < 14; i++) begin
         r = rnd();
         slow = r[0];
         ln = {6'h00, r[6:1]};
         cl = 12'(rnd() % 16'd2000);
         if (r[9:8] == 2'b00) begin
            run(nand_host_pkg::OP_STATUS, 12'h000, cur_row, 12'h000);
         end else if (r[9:8] == 2'b01 && !after_status) begin
            run(nand_host_pkg::OP_RANDOM_OUT, cl, cur_row, ln);
         end else begin
            cur_row = {r[15:14], rnd()};
            run(nand_host_pkg::OP_PAGE_READ, cl, cur_row, ln);
         end
         after_status = (r[9:8] == 2'b00);
      end
      check(dev_errs == 0, "bus protocol");
      final_report;
   end
   initial begin
      #(80000 * 50);
      n_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      final_report;
   end
endmodule : tb_nand_host_ctrl
`default_nettype wire

// *** rtl/nand_host_ctrl.sv ***
// Host controller issuing page read, column change and status read to a NAND flash
//
// Function
// - Command byte sent with command latch high
// - Address byte sent with address latch high
// - Five address cycles, column first
// - Row bits in cycles three to five
// - 00h, five addresses, 30h, busy, read
// - Read byte captured in the cycle the read strobe rises
// - 05h, two columns, E0h, resume output
// - 70h returns status, bits six and five
`timescale 1ns/1ns
`default_nettype none
module nand_host_ctrl (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire nand_host_pkg::req_t req_in,
   output logic req_ready,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic done,
   output logic status_ready_bit,
   output logic status_idle_bit,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n,
   output nand_host_pkg::pins_t pins
);
   // ************************************************************
   // State and registers
   // ************************************************************
   typedef enum logic [3:0] {ST_IDLE, ST_CMD_A, ST_ADDR, ST_CMD_B, ST_WAIT_WB, ST_WAIT_RB, ST_GAP, ST_READ,
                             ST_FINISH} state_t;

   state_t state_ff, nxt_state;
   nand_host_pkg::pins_t pins_ff, nxt_pins;
   nand_host_pkg::req_t req_ff, nxt_req;
   logic [3:0] ph_ff, nxt_ph;
   logic [2:0] idx_ff, nxt_idx;
   logic [11:0] cnt_ff, nxt_cnt;
   logic [7:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff, nxt_rd_valid;
   logic done_ff, nxt_done;
   logic ready_ff, nxt_ready;
   logic sready_ff, nxt_sready;
   logic sidle_ff, nxt_sidle;
   logic [7:0] io_sync;
   logic rb_ready;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   pin_sync #(.W(8), .RST(8'h00)) u_io_sync (
      .clk(mclk),
      .rst_n(nrst),
      .d(io_in),
      .q(io_sync)
   );

   pin_sync #(.W(1), .RST(1'b0)) u_rb_sync (
      .clk(mclk),
      .rst_n(nrst),
      .d(ready_busy_n),
      .q(rb_ready)
   );

   // ************************************************************
   // Decoding
   // ************************************************************
   logic [2:0] n_addr;
   logic [7:0] first_cmd;
   logic [7:0] second_cmd;
   logic [7:0] addr_byte;
   logic [7:0] wr_byte;
   logic [11:0] eff_len;
   logic is_write;
   logic wr_last;
   logic addr_last;
   logic plane_select_bit;

   assign n_addr = (req_ff.op == nand_host_pkg::OP_PAGE_READ) ? nand_host_pkg::ADDR_CYC_FULL :
                   (req_ff.op == nand_host_pkg::OP_RANDOM_OUT) ? nand_host_pkg::ADDR_CYC_COL :
                   nand_host_pkg::ADDR_CYC_NONE;
   assign first_cmd = (req_ff.op == nand_host_pkg::OP_PAGE_READ) ? nand_host_pkg::CMD_READ_SETUP :
                      (req_ff.op == nand_host_pkg::OP_RANDOM_OUT) ? nand_host_pkg::CMD_COL_CHANGE :
                      nand_host_pkg::CMD_STATUS;
   assign second_cmd = (req_ff.op == nand_host_pkg::OP_PAGE_READ) ? nand_host_pkg::CMD_READ_CONFIRM :
                       nand_host_pkg::CMD_COL_CONFIRM;
   // Column low, column high, then three row bytes
   assign addr_byte = (idx_ff == 3'h0) ? req_ff.col[7:0] :
                      (idx_ff == 3'h1) ? {4'h0, req_ff.col[11:8]} :
                      (idx_ff == 3'h2) ? {req_ff.row[7], plane_select_bit, req_ff.row[5:0]} :
                      (idx_ff == 3'h3) ? req_ff.row[15:8] :
                      {6'h00, req_ff.row[17:16]};
   assign plane_select_bit = req_ff.row[nand_host_pkg::PLANE_BIT_POS];
   assign wr_byte = (state_ff == ST_CMD_A) ? first_cmd : (state_ff == ST_CMD_B) ? second_cmd : addr_byte;
   assign eff_len = (req_ff.op == nand_host_pkg::OP_STATUS || req_ff.len == 12'h000) ? 12'h001 :
                    (req_ff.len > nand_host_pkg::PAGE_BYTES) ? nand_host_pkg::PAGE_BYTES : req_ff.len;
   assign is_write = (state_ff == ST_CMD_A) || (state_ff == ST_ADDR) || (state_ff == ST_CMD_B);
   assign wr_last = (ph_ff == nand_host_pkg::WE_LOW_CYC + 4'h1);
   assign addr_last = (idx_ff == n_addr - 3'h1);

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_pins = pins_ff;
      nxt_req = req_ff;
      nxt_ph = ph_ff + 4'h1;
      nxt_idx = idx_ff;
      nxt_cnt = cnt_ff;
      nxt_rd_data = rd_data_ff;
      nxt_rd_valid = 1'b0;
      nxt_done = 1'b0;
      nxt_ready = 1'b0;
      nxt_sready = sready_ff;
      nxt_sidle = sidle_ff;
      if (is_write) begin
         if (ph_ff == 4'h0) begin
            nxt_pins.we_n = 1'b0;
            nxt_pins.cle = (state_ff != ST_ADDR);
            nxt_pins.ale = (state_ff == ST_ADDR);
            nxt_pins.io_oe = 1'b1;
            nxt_pins.io_out = wr_byte;
         end else if (ph_ff == nand_host_pkg::WE_LOW_CYC) begin
            nxt_pins.we_n = 1'b1;
         end else if (wr_last) begin
            nxt_pins.cle = 1'b0;
            nxt_pins.ale = 1'b0;
            nxt_ph = 4'h0;
         end
      end
      unique case (state_ff)
         ST_IDLE: begin
            nxt_ph = 4'h0;
            nxt_idx = 3'h0;
            nxt_ready = 1'b1;
            if (req_valid && ready_ff) begin
               nxt_req = req_in;
               nxt_ready = 1'b0;
               nxt_pins.ce_n = 1'b0;
               nxt_state = ST_CMD_A;
            end
         end
         ST_CMD_A: begin
            if (wr_last) begin
               nxt_state = (n_addr == nand_host_pkg::ADDR_CYC_NONE) ? ST_GAP : ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (wr_last) begin
               nxt_idx = idx_ff + 3'h1;
               if (addr_last) begin
                  nxt_state = ST_CMD_B;
               end
            end
         end
         ST_CMD_B: begin
            if (wr_last) begin
               if (req_ff.op == nand_host_pkg::OP_PAGE_READ) begin
                  nxt_pins.ce_n = 1'b1;
                  nxt_state = ST_WAIT_WB;
               end else begin
                  nxt_state = ST_GAP;
               end
            end
         end
         ST_WAIT_WB: begin
            nxt_pins.io_oe = 1'b0;
            if (ph_ff == nand_host_pkg::BUSY_ONSET_CYC) begin
               nxt_state = ST_WAIT_RB;
            end
         end
         ST_WAIT_RB: begin
            nxt_ph = 4'h0;
            if (rb_ready) begin
               nxt_pins.ce_n = 1'b0;
               nxt_state = ST_GAP;
            end
         end
         ST_GAP: begin
            nxt_pins.io_oe = 1'b0;
            nxt_cnt = eff_len;
            if (ph_ff == nand_host_pkg::CMD_TO_READ_CYC) begin
               nxt_ph = 4'h0;
               nxt_state = ST_READ;
            end
         end
         ST_READ: begin
            // Slow strobe: byte is stable before the rising edge, no late capture needed
            if (ph_ff == 4'h0) begin
               nxt_pins.read_strobe_n = 1'b0;
            end else if (ph_ff == nand_host_pkg::RD_LOW_CYC) begin
               nxt_pins.read_strobe_n = 1'b1;
               nxt_rd_data = io_sync;
               nxt_rd_valid = 1'b1;
            end else if (ph_ff == nand_host_pkg::RD_LOW_CYC + 4'h1) begin
               nxt_ph = 4'h0;
               nxt_cnt = cnt_ff - 12'h001;
               if (cnt_ff == 12'h001) begin
                  nxt_state = ST_FINISH;
               end
            end
         end
         ST_FINISH: begin
            nxt_pins.ce_n = 1'b1;
            nxt_done = 1'b1;
            if (req_ff.op == nand_host_pkg::OP_STATUS) begin
               nxt_sready = rd_data_ff[nand_host_pkg::STATUS_READY_POS];
               nxt_sidle = rd_data_ff[nand_host_pkg::STATUS_IDLE_POS];
            end
            nxt_state = ST_IDLE;
         end
      endcase
      // Never program or erase; protect pin low keeps block protection off
      nxt_pins.wp_n = 1'b0;
      nxt_pins.powerup_protect_pin = 1'b0;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         pins_ff <= nand_host_pkg::PINS_IDLE;
         req_ff <= '0;
         ph_ff <= 4'h0;
         idx_ff <= 3'h0;
         cnt_ff <= 12'h000;
         rd_data_ff <= 8'h00;
         rd_valid_ff <= 1'b0;
         done_ff <= 1'b0;
         ready_ff <= 1'b0;
         sready_ff <= 1'b0;
         sidle_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pins_ff <= nxt_pins;
         req_ff <= nxt_req;
         ph_ff <= nxt_ph;
         idx_ff <= nxt_idx;
         cnt_ff <= nxt_cnt;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
         done_ff <= nxt_done;
         ready_ff <= nxt_ready;
         sready_ff <= nxt_sready;
         sidle_ff <= nxt_sidle;
      end
   end

   assign pins = pins_ff;
   assign req_ready = ready_ff;
   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;
   assign done = done_ff;
   assign status_ready_bit = sready_ff;
   assign status_idle_bit = sidle_ff;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   strobe_selected_a: assert property ((!pins_ff.we_n || !pins_ff.read_strobe_n) |-> !pins_ff.ce_n)
      else $error("strobe active while deselected");
   latch_exclusive_a: assert property (!(pins_ff.cle && pins_ff.ale))
      else $error("both latch enables high");
   we_rise_data_a: assert property ($rose(pins_ff.we_n) |-> pins_ff.io_oe && $stable(pins_ff.io_out))
      else $error("bus not stable at write strobe rise");
   read_bus_free_a: assert property (!pins_ff.read_strobe_n |-> !pins_ff.io_oe && pins_ff.we_n)
      else $error("host drives bus during read");
   col_high_nibble_a: assert property (pins_ff.ale && !pins_ff.we_n && idx_ff == 3'h1 |->
      pins_ff.io_out[7:4] == 4'h0)
      else $error("second column cycle upper nibble not low");
   row_top_cycle_a: assert property (pins_ff.ale && !pins_ff.we_n && idx_ff == 3'h4 |->
      pins_ff.io_out[7:2] == 6'h00)
      else $error("fifth address cycle upper bits not low");
   read_when_ready_a: assert property ($fell(pins_ff.read_strobe_n) && req_ff.op == nand_host_pkg::OP_PAGE_READ
      |-> rb_ready)
      else $error("page data read while busy");
   byte_per_strobe_a: assert property ($fell(pins_ff.read_strobe_n) |-> ##5 rd_valid_ff ##1 !rd_valid_ff)
      else $error("read strobe did not yield exactly one byte");
   protect_off_a: assert property (##1 (!pins_ff.wp_n && !pins_ff.powerup_protect_pin))
      else $error("protect pins not held low");
   confirm_then_wait_a: assert property (state_ff == ST_CMD_B && wr_last && req_ff.op == nand_host_pkg::OP_PAGE_READ
      |=> state_ff == ST_WAIT_WB && pins_ff.ce_n)
      else $error("page read confirm not followed by busy wait");
endmodule : nand_host_ctrl
`default_nettype wire

// *** rtl/nand_host_pkg.sv ***
// Shared constants and types for the flash page read controller
package nand_host_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_NS = 50;
   localparam int BUSY_ONSET_NS = 100;
   localparam int CMD_TO_READ_NS = 120;
   localparam logic [3:0] BUSY_ONSET_CYC = 4'((BUSY_ONSET_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] CMD_TO_READ_CYC = 4'((CMD_TO_READ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WE_LOW_CYC = 4'h2;
   localparam logic [3:0] RD_LOW_CYC = 4'h5;

   // ************************************************************
   // Page geometry and address layout
   // ************************************************************
   localparam logic [11:0] PAGE_MAIN = 12'h800;
   localparam logic [11:0] PAGE_SPARE = 12'h040;
   localparam logic [11:0] PAGE_BYTES = PAGE_MAIN + PAGE_SPARE;
   localparam int PAGES_PER_BLOCK = 64;
   localparam int PLANE_BIT_POS = 6;
   localparam logic [2:0] ADDR_CYC_FULL = 3'h5;
   localparam logic [2:0] ADDR_CYC_COL = 3'h2;
   localparam logic [2:0] ADDR_CYC_NONE = 3'h0;

   // ************************************************************
   // Commands and status fields
   // ************************************************************
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
   localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam int STATUS_READY_POS = 6;
   localparam int STATUS_IDLE_POS = 5;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {OP_PAGE_READ, OP_RANDOM_OUT, OP_STATUS} op_t;

   typedef struct packed {
      op_t op;
      logic [11:0] col;
      logic [17:0] row;
      logic [11:0] len;
   } req_t;

   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic wp_n;
      logic powerup_protect_pin;
      logic io_oe;
      logic [7:0] io_out;
   } pins_t;

   localparam pins_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                                   wp_n: 1'b0, powerup_protect_pin: 1'b0, io_oe: 1'b0, io_out: 8'h00};
endpackage : nand_host_pkg

// *** rtl/pin_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic agree;

   assign agree = (s2_ff == s3_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
         q <= RST;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (agree) begin
            q <= s3_ff;
         end
      end
   end
endmodule : pin_sync
`default_nettype wire
